// *** edc_defines.svh ***
`ifndef EDC_DEFINES_SVH
`define EDC_DEFINES_SVH
`define EDC_NUM_CH 4
`define EDC_FIFO_DEPTH 32
`define EDC_DATA_W 8
`define EDC_PER_BLK_MAX 17'h00100
`define EDC_STD_BLK_MAX 17'h10000
`define EDC_RLD_NONE 2'h0
`define EDC_RLD_BURST 2'h1
`define EDC_RLD_BLOCK 2'h2
`define EDC_RLD_TRANS 2'h3
`define EDC_TRG_SW 2'h0
`define EDC_TRG_PERIPH 2'h1
`define EDC_TRG_EVENT 2'h2
`define EDC_TSEL_DIR_BIT 7
`define EDC_PERIPH_BASE 16'h0800
`define EDC_NVM_FIRST 16'h1000
`define EDC_NVM_LAST 16'h1FFF
`endif

// *** edc_pkg.sv ***
package edc_pkg;
  typedef enum logic [3:0] {
    EDC_IDLE = 4'h1,
    EDC_READ = 4'h2,
    EDC_WRITE = 4'h4,
    EDC_END = 4'h8
  } edc_state_t;

  typedef struct packed {
    logic en;
    logic req;
    logic pend;
    logic rep_done;
    logic [15:0] sa;
    logic [15:0] da;
    logic [16:0] cnt;
  } edc_chan_t;

  typedef struct packed {
    edc_state_t state;
    edc_chan_t [3:0] ch;
    logic [1:0] cur;
    logic [1:0] last;
    logic [1:0] bidx;
    logic rd_wait;
    logic hit;
    logic [7:0] lo;
    logic [15:0] ps1;
    logic [15:0] ps2;
    logic [15:0] ps3;
    logic [3:0] es1;
    logic [3:0] es2;
    logic [3:0] es3;
    logic [3:0] done;
    logic [3:0] err;
  } edc_core_t;
endpackage : edc_pkg

// *** edc_stream_if.sv ***
`timescale 1ns/1ps
interface edc_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport producer(output valid, output data, input ready);
  modport consumer(input valid, input data, output ready);
endinterface : edc_stream_if

// *** edc_fifo.sv ***
`timescale 1ns/1ps
module edc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  // clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // streams
  edc_stream_if.consumer in_s,
  edc_stream_if.producer out_s
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
  } edc_fifo_t;
  edc_fifo_t r;
  edc_fifo_t n;
  logic push;
  logic pop;

  assign in_s.ready = (r.count != (AW+1)'(DEPTH));
  assign out_s.valid = (r.count != '0);
  assign out_s.data = r.mem[r.rptr];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wptr] = in_s.data;
      n.wptr = (r.wptr == AW'(DEPTH-1)) ? '0 : r.wptr + 1'b1;
    end
    if (pop) begin
      n.rptr = (r.rptr == AW'(DEPTH-1)) ? '0 : r.rptr + 1'b1;
    end
    n.count = r.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end
endmodule : edc_fifo

// *** edc_enhanced_dma.sv ***
`timescale 1ns/1ps
`include "edc_defines.svh"
module edc_enhanced_dma #(
  parameter int FIFO_DEPTH = `EDC_FIFO_DEPTH
) (
  // clock, reset, freeze
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic CE,
  // global configuration
  input wire logic [1:0] CHANNEL_ARRANGEMENT_SELECT,
  input wire logic PRIO_ROUND_ROBIN,
  input wire logic NVM_OFF,
  // per-channel configuration, channel c in bit c or slice c
  input wire logic [3:0] CH_ENABLE_SET,
  input wire logic [3:0] CH_DISABLE,
  input wire logic [3:0] CH_BURST2,
  input wire logic [3:0] CH_REPEAT,
  input wire logic [3:0] CH_SINGLE_SHOT,
  input wire logic [3:0] CH_ADDR_INC,
  input wire logic [7:0] CH_RELOAD,
  input wire logic [3:0] CH_MATCH,
  input wire logic [3:0] CH_LINK,
  input wire logic [3:0] CH_SW_TRIG,
  input wire logic [31:0] TRIGGER_SOURCE_SELECT,
  input wire logic [63:0] MEMORY_POINTER,
  input wire logic [63:0] BLOCK_BYTE_COUNTER,
  // asynchronous trigger pins
  input wire logic [15:0] PERIPH_TRIG,
  input wire logic [3:0] EVENT_TRIG,
  // channel status
  output logic [3:0] CH_ENABLED,
  output logic [3:0] CH_BUSY,
  output logic [3:0] CH_DONE,
  output logic [3:0] CH_ERROR,
  output logic [63:0] CH_SRC_PTR,
  // shared data bus master port
  output logic MST_REQ,
  input wire logic MST_GNT,
  input wire logic CPU_REQ,
  output logic MST_EN,
  output logic MST_WE,
  output logic [15:0] MST_ADDR,
  output logic [7:0] MST_WDATA,
  input wire logic [7:0] MST_RDATA,
  input wire logic MST_RVALID
);
  edc_pkg::edc_core_t r;
  edc_pkg::edc_core_t n;
  edc_stream_if #(.W(`EDC_DATA_W)) fin ();
  edc_stream_if #(.W(`EDC_DATA_W)) fout ();
  logic [3:0] std_ch;
  logic [3:0] slave;
  logic [3:0] ready;
  logic [3:0] trig;
  logic [3:0] mt;
  logic [3:0] fre;
  logic [3:0] eff_rep;
  logic [3:0] link_ok;
  logic [3:0] inc_s;
  logic [3:0] inc_d;
  logic [3:0] acc_err;
  logic [1:0] rld_s [4];
  logic [1:0] rld_d [4];
  logic [1:0] link_tgt [4];
  logic [15:0] ld_sa [4];
  logic [15:0] ld_da [4];
  logic [15:0] pat [4];
  logic [16:0] ld_cnt [4];
  logic [15:0] per_edge;
  logic [3:0] evt_edge;
  logic [1:0] len;
  logic rd_go;
  logic in_rd;
  logic in_wr;

  function automatic logic in_nvm(input logic [15:0] a);
    in_nvm = (a >= `EDC_NVM_FIRST) && (a <= `EDC_NVM_LAST);
  endfunction : in_nvm

  // edges are taken from the second and third stages only
  assign per_edge = r.ps2 & ~r.ps3;
  assign evt_edge = r.es2 & ~r.es3;

  for (genvar c = 0; c < 4; c++) begin : g_ch
    localparam int PO = c | 1;
    localparam int PX = c ^ 2;
    logic [7:0] ts;
    logic dir;
    logic [15:0] paddr;
    logic [15:0] cnt_raw;
    assign ts = TRIGGER_SOURCE_SELECT[c*8 +: 8];
    assign dir = ts[`EDC_TSEL_DIR_BIT];
    assign std_ch[c] = (c % 2 == 0) && CHANNEL_ARRANGEMENT_SELECT[c/2];
    assign slave[c] = (c % 2 == 1) && CHANNEL_ARRANGEMENT_SELECT[c/2];
    assign paddr = `EDC_PERIPH_BASE + {8'h00, ts[6:0], 1'b0};
    assign ld_sa[c] = std_ch[c] ? MEMORY_POINTER[c*16 +: 16] : (dir ? paddr : MEMORY_POINTER[c*16 +: 16]);
    assign ld_da[c] = std_ch[c] ? MEMORY_POINTER[PO*16 +: 16] : (dir ? MEMORY_POINTER[c*16 +: 16] : paddr);
    assign inc_s[c] = std_ch[c] ? CH_ADDR_INC[c] : (!dir && CH_ADDR_INC[c]);
    assign inc_d[c] = std_ch[c] ? CH_ADDR_INC[PO] : (dir && CH_ADDR_INC[c]);
    assign rld_s[c] = std_ch[c] ? CH_RELOAD[c*2 +: 2] : (dir ? `EDC_RLD_NONE : CH_RELOAD[c*2 +: 2]);
    assign rld_d[c] = std_ch[c] ? CH_RELOAD[PO*2 +: 2] : (dir ? CH_RELOAD[c*2 +: 2] : `EDC_RLD_NONE);
    assign cnt_raw = std_ch[c] ? BLOCK_BYTE_COUNTER[c*16 +: 16] : {8'h00, BLOCK_BYTE_COUNTER[c*16 +: 8]};
    assign mt[c] = CH_MATCH[c] && (std_ch[c] || dir);
    assign fre[c] = mt[c] && (cnt_raw == 16'h0000);
    assign ld_cnt[c] = (cnt_raw != 16'h0000) ? {1'b0, cnt_raw} :
                       fre[c] ? 17'h00000 : (std_ch[c] ? `EDC_STD_BLK_MAX : `EDC_PER_BLK_MAX);
    assign pat[c] = std_ch[c] ? MEMORY_POINTER[PO*16 +: 16] : MEMORY_POINTER[c*16 +: 16];
    assign link_tgt[c] = std_ch[c] ? 2'(PX) : 2'(PO);
    assign link_ok[c] = std_ch[c] ? (std_ch[PX] && CH_LINK[PX]) :
                        ((c % 2 == 0) && !slave[PO] && CH_LINK[PO]);
    assign eff_rep[c] = CH_REPEAT[c] && !CH_LINK[c] && !link_ok[c] && !mt[c];
    assign trig[c] = CH_SW_TRIG[c] ||
                     (ts[5:4] == `EDC_TRG_PERIPH && per_edge[ts[3:0]]) ||
                     (ts[5:4] == `EDC_TRG_EVENT && evt_edge[ts[1:0]]);
    assign acc_err[c] = in_nvm(r.ch[c].da) || (NVM_OFF && in_nvm(r.ch[c].sa));
    assign ready[c] = r.ch[c].en && r.ch[c].req && !slave[c];
    assign CH_SRC_PTR[c*16 +: 16] = r.ch[c].sa;
    assign CH_ENABLED[c] = r.ch[c].en;
    assign CH_BUSY[c] = r.ch[c].req;
  end

  assign len = CH_BURST2[r.cur] ? 2'h2 : 2'h1;
  assign in_rd = (r.state == edc_pkg::EDC_READ);
  assign in_wr = (r.state == edc_pkg::EDC_WRITE);
  // match and search throw the data away, so they never wait for space
  assign rd_go = fin.ready || mt[r.cur];
  assign MST_REQ = (r.state != edc_pkg::EDC_IDLE) || (|ready);
  assign MST_EN = (in_rd && !r.rd_wait && rd_go) || (in_wr && fout.valid);
  assign MST_WE = in_wr;
  assign MST_ADDR = in_wr ? r.ch[r.cur].da + {14'h0000, r.bidx} : r.ch[r.cur].sa + {14'h0000, r.bidx};
  assign MST_WDATA = fout.data;
  assign fin.valid = in_rd && r.rd_wait && MST_RVALID && !mt[r.cur];
  assign fin.data = MST_RDATA;
  assign fout.ready = in_wr;
  assign CH_DONE = r.done;
  assign CH_ERROR = r.err;

  edc_fifo #(.W(`EDC_DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(SYS_CLK),
    .rst(RESET),
    .ce(CE),
    .in_s(fin),
    .out_s(fout)
  );

  always_comb begin
    logic found;
    logic [1:0] w;
    logic [1:0] k;
    logic [1:0] t;
    logic blk_end;
    found = 1'b0;
    w = r.cur;
    k = 2'h0;
    t = 2'h0;
    blk_end = 1'b0;
    n = r;
    n.done = 4'h0;
    n.err = 4'h0;
    n.ps1 = PERIPH_TRIG;
    n.ps2 = r.ps1;
    n.ps3 = r.ps2;
    n.es1 = EVENT_TRIG;
    n.es2 = r.es1;
    n.es3 = r.es2;
    case (r.state)
      edc_pkg::EDC_IDLE: begin
        for (int i = 0; i < 4; i++) begin
          k = PRIO_ROUND_ROBIN ? 2'(r.last + 2'(i) + 2'h1) : 2'(i);
          if (!found && ready[k]) begin
            found = 1'b1;
            w = k;
          end
        end
        if (found && MST_GNT && !CPU_REQ) begin
          n.cur = w;
          n.last = w;
          n.bidx = 2'h0;
          n.hit = 1'b0;
          n.rd_wait = 1'b0;
          if (acc_err[w]) begin
            n.err[w] = 1'b1;
            n.ch[w].en = 1'b0;
            n.ch[w].req = 1'b0;
          end else begin
            n.state = edc_pkg::EDC_READ;
          end
        end
      end
      edc_pkg::EDC_READ: begin
        if (!r.rd_wait) begin
          n.rd_wait = rd_go;
        end else if (MST_RVALID) begin
          n.rd_wait = 1'b0;
          n.lo = MST_RDATA;
          n.bidx = r.bidx + 2'h1;
          if (mt[r.cur] && (len == 2'h1 ? MST_RDATA == pat[r.cur][7:0] :
              (r.bidx == 2'h1 && {MST_RDATA, r.lo} == pat[r.cur]))) begin
            n.hit = 1'b1;
          end
          if (r.bidx + 2'h1 == len) begin
            n.bidx = 2'h0;
            n.state = mt[r.cur] ? edc_pkg::EDC_END : edc_pkg::EDC_WRITE;
          end
        end
      end
      edc_pkg::EDC_WRITE: begin
        if (fout.valid) begin
          n.bidx = r.bidx + 2'h1;
          if (r.bidx + 2'h1 == len) begin
            n.state = edc_pkg::EDC_END;
          end
        end
      end
      edc_pkg::EDC_END: begin
        n.state = edc_pkg::EDC_IDLE;
        n.bidx = 2'h0;
        // a hit keeps the source pointer on the matching data unless the source reloads per burst
        if (!r.hit && inc_s[r.cur]) begin
          n.ch[r.cur].sa = r.ch[r.cur].sa + {14'h0000, len};
        end
        if (inc_d[r.cur]) begin
          n.ch[r.cur].da = r.ch[r.cur].da + {14'h0000, len};
        end
        if (rld_s[r.cur] == `EDC_RLD_BURST) begin
          n.ch[r.cur].sa = ld_sa[r.cur];
        end
        if (rld_d[r.cur] == `EDC_RLD_BURST) begin
          n.ch[r.cur].da = ld_da[r.cur];
        end
        blk_end = !fre[r.cur] && (r.ch[r.cur].cnt <= {15'h0000, len});
        n.ch[r.cur].cnt = blk_end ? ld_cnt[r.cur] : r.ch[r.cur].cnt - {15'h0000, len};
        if (blk_end && !r.hit) begin
          if (rld_s[r.cur] == `EDC_RLD_BLOCK) begin
            n.ch[r.cur].sa = ld_sa[r.cur];
          end
          if (rld_d[r.cur] == `EDC_RLD_BLOCK) begin
            n.ch[r.cur].da = ld_da[r.cur];
          end
        end
        if (r.hit) begin
          n.done[r.cur] = 1'b1;
          n.ch[r.cur].en = 1'b0;
          n.ch[r.cur].req = 1'b0;
          n.ch[r.cur].cnt = ld_cnt[r.cur];
        end else if (blk_end && mt[r.cur]) begin
          n.err[r.cur] = 1'b1;
          n.ch[r.cur].en = 1'b0;
          n.ch[r.cur].req = 1'b0;
        end else if (blk_end && eff_rep[r.cur] && !r.ch[r.cur].rep_done) begin
          n.ch[r.cur].rep_done = 1'b1;
          n.ch[r.cur].req = 1'b1;
        end else if (blk_end) begin
          n.done[r.cur] = 1'b1;
          n.ch[r.cur].en = 1'b0;
          n.ch[r.cur].req = 1'b0;
          if (rld_s[r.cur] == `EDC_RLD_TRANS) begin
            n.ch[r.cur].sa = ld_sa[r.cur];
          end
          if (rld_d[r.cur] == `EDC_RLD_TRANS) begin
            n.ch[r.cur].da = ld_da[r.cur];
          end
          if (link_ok[r.cur]) begin
            t = link_tgt[r.cur];
            n.ch[t].en = 1'b1;
            n.ch[t].sa = ld_sa[t];
            n.ch[t].da = ld_da[t];
            n.ch[t].cnt = ld_cnt[t];
            n.ch[t].rep_done = 1'b0;
          end
        end else if (CH_SINGLE_SHOT[r.cur]) begin
          n.ch[r.cur].req = 1'b0;
        end
      end
      default: begin
        n.state = edc_pkg::EDC_IDLE;
      end
    endcase
    for (int c = 0; c < 4; c++) begin
      if (CH_ENABLE_SET[c] && !slave[c]) begin
        n.ch[c].en = 1'b1;
        n.ch[c].sa = ld_sa[c];
        n.ch[c].da = ld_da[c];
        n.ch[c].cnt = ld_cnt[c];
        n.ch[c].rep_done = 1'b0;
      end
      if (CH_DISABLE[c]) begin
        n.ch[c].en = 1'b0;
        n.ch[c].req = 1'b0;
        // an aborted channel must not restart from a stale stored trigger
        n.ch[c].pend = 1'b0;
        n.err[c] = r.ch[c].req || (r.state != edc_pkg::EDC_IDLE && r.cur == 2'(c));
      end
      // a stored trigger may only wait once; extra ones are dropped
      if (n.ch[c].en && trig[c]) begin
        if (!n.ch[c].req) begin
          n.ch[c].req = 1'b1;
        end else begin
          n.ch[c].pend = 1'b1;
        end
      end else if (n.ch[c].en && !n.ch[c].req && n.ch[c].pend) begin
        n.ch[c].req = 1'b1;
        n.ch[c].pend = 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      r <= '0;
      r.state <= edc_pkg::EDC_IDLE;
    end else if (CE) begin
      r <= n;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET || !CE);

  burst_len_a: assert property ((in_rd || in_wr) |->
    (r.bidx < (CH_BURST2[r.cur] ? 2'h2 : 2'h1))) else $error("burst length wrong");
  bus_hold_a: assert property ((in_rd || in_wr) |=>
    (MST_REQ && r.state != edc_pkg::EDC_IDLE)) else $error("bus dropped inside burst");
  cpu_first_a: assert property ((r.state == edc_pkg::EDC_IDLE && CPU_REQ) |=>
    r.state == edc_pkg::EDC_IDLE) else $error("burst started over processor");
  per_blk_a: assert property (!std_ch[0] |-> r.ch[0].cnt <= `EDC_PER_BLK_MAX) else $error("peripheral block too big");
  std_blk_a: assert property (r.ch[2].cnt <= `EDC_STD_BLK_MAX) else $error("standard block too big");
  repeat_once_a: assert property ((CH_DONE[2] && eff_rep[2] && !r.ch[2].en) |->
    r.ch[2].rep_done) else $error("repeat block skipped");
  self_off_a: assert property ((r.state == edc_pkg::EDC_END && n.done[r.cur] && !CH_ENABLE_SET[r.cur]) |=>
    !r.ch[$past(r.cur)].en) else $error("channel stayed enabled after completion");
  pend_keep_a: assert property ((r.ch[0].en && r.ch[0].req && trig[0] && !CH_DISABLE[0] && !acc_err[0] &&
    r.state != edc_pkg::EDC_END) |=> r.ch[0].pend) else $error("pending trigger lost");
  slave_idle_a: assert property (CHANNEL_ARRANGEMENT_SELECT[0] |-> !ready[1]) else $error("merged half active");
  nvm_write_a: assert property ((MST_EN && MST_WE) |-> !in_nvm(MST_ADDR)) else $error("write into nvm");
endmodule : edc_enhanced_dma

// *** edc_bus_partner.sv ***
`timescale 1ns/1ps
module edc_bus_partner (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench controls
  input wire logic cpu_want,
  input wire logic slow,
  // master port of the controller
  input wire logic mst_req,
  output logic mst_gnt,
  output logic cpu_req,
  input wire logic mst_en,
  input wire logic mst_we,
  input wire logic [15:0] mst_addr,
  input wire logic [7:0] mst_wdata,
  output logic [7:0] mst_rdata,
  output logic mst_rvalid
);
  logic [23:0] wq[$];
  logic [1:0] wait_cnt;
  logic pend;
  logic [15:0] raddr;
  function automatic logic [7:0] mv(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : mv
  // the processor always wins; a mid-burst processor request is left to the controller
  assign cpu_req = cpu_want;
  assign mst_gnt = mst_req & ~cpu_want;
  always @(posedge clk) begin
    mst_rvalid <= 1'b0;
    // idle read data toggles so a stale byte never looks valid
    mst_rdata <= ~mst_rdata;
    if (rst) begin
      pend <= 1'b0;
      wait_cnt <= 2'h0;
      mst_rdata <= 8'hA5;
    end else begin
      if (mst_en && mst_we) begin
        wq.push_back({mst_addr, mst_wdata});
      end
      if (mst_en && !mst_we) begin
        pend <= 1'b1;
        raddr <= mst_addr;
        wait_cnt <= slow ? 2'h3 : 2'h0;
      end else if (pend && wait_cnt == 2'h0) begin
        mst_rvalid <= 1'b1;
        mst_rdata <= mv(raddr);
        pend <= 1'b0;
      end else if (pend) begin
        wait_cnt <= wait_cnt - 2'h1;
      end
    end
  end
endmodule : edc_bus_partner

// *** edc_enhanced_dma_tb.sv ***
`timescale 1ns/1ps
`include "edc_defines.svh"
module edc_enhanced_dma_tb;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic rr = 1'b0, nvm_off = 1'b0, cpu_want = 1'b0, slow = 1'b0, noise = 1'b0, hold = 1'b0;
  logic [1:0] arr = 2'h0;
  logic [3:0] en_set = 4'h0, dis = 4'h0, b2 = 4'h0, rep = 4'h0, ss = 4'h0, inc = 4'h0, mt = 4'h0, swt = 4'h0;
  logic [7:0] rld = 8'h00;
  logic [31:0] tsel = 32'h0;
  logic [63:0] mptr = 64'h0, bcnt = 64'h0, src_ptr;
  logic [15:0] ptrig = 16'h0, mst_addr, sa, da;
  logic [3:0] etrig = 4'h0, enabled, busy, done, error;
  logic mst_req, mst_gnt, cpu_req, mst_en, mst_we, mst_rvalid;
  logic [7:0] mst_wdata, mst_rdata;
  logic [1:0] fin;
  logic [3:0] lnk = 4'h0;
  logic arm = 1'b0;
  logic [7:0] seen = 8'h00;
  int err_count = 0;
  int cmp_count = 0;
  int n, k, c, idx;

  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cpu_want <= hold | (noise & ($urandom_range(3) == 0));
  // done and error are one-cycle pulses, so they are caught here and kept until the next fire
  always @(posedge sys_clk) seen <= arm ? (seen | {error, done}) : 8'h00;

  edc_enhanced_dma u_dut (.SYS_CLK(sys_clk), .RESET(reset), .CE(1'b1), .CHANNEL_ARRANGEMENT_SELECT(arr),
    .PRIO_ROUND_ROBIN(rr), .NVM_OFF(nvm_off), .CH_ENABLE_SET(en_set), .CH_DISABLE(dis), .CH_BURST2(b2),
    .CH_REPEAT(rep), .CH_SINGLE_SHOT(ss), .CH_ADDR_INC(inc), .CH_RELOAD(rld), .CH_MATCH(mt), .CH_LINK(lnk),
    .CH_SW_TRIG(swt), .TRIGGER_SOURCE_SELECT(tsel), .MEMORY_POINTER(mptr), .BLOCK_BYTE_COUNTER(bcnt),
    .PERIPH_TRIG(ptrig), .EVENT_TRIG(etrig), .CH_ENABLED(enabled), .CH_BUSY(busy), .CH_DONE(done),
    .CH_ERROR(error), .CH_SRC_PTR(src_ptr), .MST_REQ(mst_req), .MST_GNT(mst_gnt), .CPU_REQ(cpu_req),
    .MST_EN(mst_en), .MST_WE(mst_we), .MST_ADDR(mst_addr), .MST_WDATA(mst_wdata), .MST_RDATA(mst_rdata),
    .MST_RVALID(mst_rvalid));

  edc_bus_partner u_bus (.clk(sys_clk), .rst(reset), .cpu_want(cpu_want), .slow(slow), .mst_req(mst_req),
    .mst_gnt(mst_gnt), .cpu_req(cpu_req), .mst_en(mst_en), .mst_we(mst_we), .mst_addr(mst_addr),
    .mst_wdata(mst_wdata), .mst_rdata(mst_rdata), .mst_rvalid(mst_rvalid));

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask : chk

  task automatic clr;
    @(posedge sys_clk);
    {b2, rep, ss, inc, mt, rld, tsel, lnk} <= '0;
    @(posedge sys_clk);
  endtask : clr

  // waits for completion or error of one channel, never longer than the bound
  task automatic wait_end(input int ch);
    int i;
    fin = 2'b00;
    for (i = 0; i < 6000 && fin == 2'b00; i++) begin
      @(posedge sys_clk);
      #1;
      fin = {seen[4 + ch], seen[ch]};
    end
    if (fin == 2'b00) begin
      $display("Error wait_end expected 1 seen 0");
      err_count++;
      complete_run();
    end
  endtask : wait_end

  task automatic fire(input int ch, input int kind, input int ix);
    u_bus.wq.delete();
    @(posedge sys_clk);
    en_set[ch] <= 1'b1;
    arm <= 1'b0;
    @(posedge sys_clk);
    en_set <= 4'h0;
    arm <= 1'b1;
    @(posedge sys_clk);
    if (kind == 0) swt[ch] <= 1'b1;
    if (kind == 1) ptrig[ix] <= 1'b1;
    if (kind == 2) etrig[ix] <= 1'b1;
    @(posedge sys_clk);
    swt <= 4'h0;
    repeat (3) @(posedge sys_clk);
    ptrig <= 16'h0;
    etrig <= 4'h0;
  endtask : fire

  // low byte of each write is the partner's read pattern of the matching source byte
  task automatic chk_wr(input logic [15:0] d, input logic di, input logic [15:0] s, input int cnt, input int blk);
    int i;
    logic [23:0] w;
    chk("write_count", cnt, u_bus.wq.size());
    for (i = 0; i < cnt && u_bus.wq.size() > 0; i++) begin
      w = u_bus.wq.pop_front();
      chk("write", {d + (di ? 16'(i % blk) : 16'h0), u_bus.mv(s + 16'(i))}, w);
    end
  endtask : chk_wr

  initial begin
    void'($urandom(32'h4D02));
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    arr <= 2'h3;
    noise <= 1'b1;
    for (k = 0; k < 2; k++) begin
      clr();
      n = 2 * (1 + $urandom_range(5));
      sa = 16'h2000 + 16'($urandom_range(4095));
      da = 16'h4000 + 16'($urandom_range(4095));
      b2[0] <= k[0];
      mptr[31:0] <= {da, sa};
      bcnt[15:0] <= 16'(n);
      inc <= 4'h3;
      slow <= k[0];
      rr <= 1'($urandom_range(1));
      lnk[2] <= k[0];
      fire(0, 0, 0);
      wait_end(0);
      chk("copy_done", 2'b01, fin);
      chk_wr(da, 1'b1, sa, n, n);
      chk("enabled", 0, enabled[0]);
      chk("link_enable", k[0], enabled[2]);
      $display("test copy burst %0d finished", k + 1);
    end
    clr();
    sa = 16'h2000 + 16'($urandom_range(4095));
    da = 16'h4000 + 16'($urandom_range(4095));
    mptr[63:32] <= {da, sa};
    bcnt[47:32] <= 16'h0003;
    inc <= 4'hC;
    rep[2] <= 1'b1;
    rld[7:6] <= `EDC_RLD_BLOCK;
    fire(2, 0, 0);
    wait_end(2);
    chk("repeat_done", 2'b01, fin);
    chk_wr(da, 1'b1, sa, 6, 3);
    $display("test repeat finished");
    arr <= 2'h0;
    for (k = 0; k < 2; k++) begin
      clr();
      n = k ? 5 : 256;
      c = k ? 3 : 1;
      idx = $urandom_range(k ? 3 : 15);
      sa = 16'h3000 + 16'($urandom_range(255));
      tsel[8*c +: 8] <= {2'b00, k ? `EDC_TRG_EVENT : `EDC_TRG_PERIPH, 4'(idx)};
      mptr[16*c +: 16] <= sa;
      bcnt[16*c +: 16] <= 16'(n % 256);
      inc[c] <= 1'b1;
      fire(c, k + 1, idx);
      wait_end(c);
      chk("periph_done", 2'b01, fin);
      chk_wr(`EDC_PERIPH_BASE + 16'(2 * ((k + 1) * 16 + idx)), 1'b0, sa, n, n);
      $display("test peripheral %0d finished", k + 1);
    end
    arr <= 2'h1;
    for (k = 0; k < 3; k++) begin
      clr();
      nvm_off <= (k == 1);
      sa = k ? `EDC_NVM_FIRST + 16'($urandom_range(4000)) : 16'h2100;
      da = k ? 16'h5000 : `EDC_NVM_FIRST + 16'($urandom_range(4000));
      mptr[31:0] <= {da, sa};
      bcnt[15:0] <= 16'h0004;
      inc <= 4'h3;
      fire(0, 0, 0);
      wait_end(0);
      chk("nvm_finish", k == 2 ? 2'b01 : 2'b10, fin);
      chk_wr(da, 1'b1, sa, k == 2 ? 4 : 0, 4);
    end
    $display("test storage window finished");
    arr <= 2'h2;
    for (k = 0; k < 2; k++) begin
      clr();
      sa = {4'h6, 4'($urandom_range(15)), 4'($urandom_range(15)), 4'h0};
      n = $urandom_range(7);
      mt[2] <= 1'b1;
      inc <= 4'h4;
      mptr[63:32] <= {8'h00, k ? u_bus.mv(sa) ^ 8'h80 : u_bus.mv(sa + 16'(n)), sa};
      bcnt[47:32] <= 16'h0008;
      fire(2, 0, 0);
      wait_end(2);
      chk("search_finish", k ? 2'b10 : 2'b01, fin);
      if (k == 0) chk("hit_ptr", sa + 16'(n), src_ptr[47:32]);
      chk_wr(16'h0, 1'b0, 16'h0, 0, 1);
    end
    $display("test search finished");
    // processor holds the bus so the extra triggers land while a request is outstanding
    arr <= 2'h1;
    clr();
    noise <= 1'b0;
    hold <= 1'b1;
    mptr[31:0] <= {16'h4800, 16'h2800};
    bcnt[15:0] <= 16'h0004;
    inc <= 4'h3;
    ss[0] <= 1'b1;
    fire(0, 0, 0);
    for (k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      swt[0] <= 1'b1;
      @(posedge sys_clk);
      swt[0] <= 1'b0;
    end
    n = 0;
    repeat (30) begin
      @(posedge sys_clk);
      #1;
      if (mst_en === 1'b1) n++;
    end
    chk("stalled_access", 0, n);
    chk("busy", 1, busy[0]);
    hold <= 1'b0;
    repeat (200) @(posedge sys_clk);
    chk_wr(16'h4800, 1'b1, 16'h2800, 2, 2);
    chk("enabled", 1, enabled[0]);
    hold <= 1'b1;
    swt[0] <= 1'b1;
    @(posedge sys_clk);
    swt[0] <= 1'b0;
    repeat (5) @(posedge sys_clk);
    dis[0] <= 1'b1;
    @(posedge sys_clk);
    dis[0] <= 1'b0;
    wait_end(0);
    chk("abort_finish", 2'b10, fin);
    hold <= 1'b0;
    $display("test pending and abort finished");
    complete_run();
  end
endmodule : edc_enhanced_dma_tb
